// [design/drct_pkg.sv]
// Constants, types and register map of the dual reload countdown timers.
// Assumes a 100 MHz system clock and a 32-bit AHB-Lite register bus.
// Functional notes
// - First timer loads reload bytes on start
// - First reload low byte, read/write
// - Second reload bytes apply at next start
// - Second control field layout, bits 6,2 reserved
// - Stop-on-receive halts after four received bits
// - Trimming modes ignore stop-on-receive
// - Mode 00 no auto start; 01 tx end
// - Modes 10/11 trim on oscillator rising edges
// - Auto restart reloads and continues at zero; in mode 10 the count rests at zero instead
// - Without auto restart, stop at zero; in mode 10 the timer keeps running at zero instead
// - Second underflow sets interrupt flag
// - Clock select 00 fast, 01 slow tick
// - Clock select 10 first, 11 third underflow
// - Run control bits written only under mask
// - First timer auto restart like second
// - First timer stop-on-receive after four bits
// - First clock select: fast, slow, third, second
package drct_pkg;
    // ========================================
    // Register indexes (byte address is four times)
    localparam logic [7:0] IDX_RUN_CTRL   = 8'h0E;
    localparam logic [7:0] IDX_T0_CTRL    = 8'h0F;
    localparam logic [7:0] IDX_T0_RLD_HI  = 8'h10;
    localparam logic [7:0] IDX_T0_RLD_LO  = 8'h11;
    localparam logic [7:0] IDX_T0_CNT_HI  = 8'h12;
    localparam logic [7:0] IDX_T0_CNT_LO  = 8'h13;
    localparam logic [7:0] IDX_T1_CTRL    = 8'h14;
    localparam logic [7:0] IDX_T1_RLD_HI  = 8'h15;
    localparam logic [7:0] IDX_T1_RLD_LO  = 8'h16;
    localparam logic [7:0] IDX_T1_CNT_HI  = 8'h17;
    localparam logic [7:0] IDX_T1_CNT_LO  = 8'h18;
    localparam logic [7:0] IDX_IRQ_STATUS = 8'h20;
    // ========================================
    // Field positions
    localparam int RUN_MASK_T0   = 0;
    localparam int RUN_MASK_T1   = 1;
    localparam int RUN_STATE_T0  = 4;
    localparam int RUN_STATE_T1  = 5;
    localparam int IRQ_FLAG_BIT  = 0;
    localparam logic [7:0] CTRL_WR_MASK = 8'hBB;
    // ========================================
    // Reset values
    localparam logic [7:0]  CTRL_RST   = 8'h00;
    localparam logic [15:0] RELOAD_RST = 16'h0000;
    // ========================================
    // Tick generation: fast tick by phase accumulation
    localparam int SYS_CLK_HZ  = 100_000_000;
    localparam int FAST_CLK_HZ = 13_560_000;
    localparam int SLOW_CLK_HZ = 211_875;
    localparam int PHASE_GRAIN = 10_000;
    localparam logic [13:0] FAST_STEP = 14'(FAST_CLK_HZ / PHASE_GRAIN);
    localparam logic [13:0] FAST_MOD  = 14'(SYS_CLK_HZ / PHASE_GRAIN);
    localparam logic [5:0]  SLOW_LAST = 6'(FAST_CLK_HZ / SLOW_CLK_HZ - 1);
    // ========================================
    // AHB-Lite
    localparam logic [1:0] HTRANS_NONSEQ = 2'h2;
    // ========================================
    // Types
    typedef enum logic [1:0] {
        DRCT_START_NONE, DRCT_START_TX_END, DRCT_START_TRIM, DRCT_START_TRIM_UF
    } drct_start_t;
    typedef struct packed {
        logic        stop_rx;      // Stop on receive
        logic        rsvd6;        // Reserved
        drct_start_t start_mode;   // Start mode
        logic        auto_restart; // Auto restart
        logic        rsvd2;        // Reserved
        logic [1:0]  clk_sel;      // Clock select
    } drct_ctrl_t;
endpackage

// [design/drct_countdown.sv]
// One 16-bit reload countdown timer.
// Assumes tick, start and stop are one-cycle pulses on sys_clk.
`timescale 1ns/1ns
`default_nettype none
module drct_countdown (
    input  wire logic        sys_clk,
    input  wire logic        rst_n,
    input  wire logic        tick,
    input  wire logic        start,
    input  wire logic        stop,
    input  wire logic        no_underflow,
    input  wire logic        auto_restart,
    input  wire logic [15:0] reload,
    output logic      [15:0] count_q,
    output logic             running_q,
    output logic             underflow_q
);
    // ========================================
    // Next state
    logic [15:0] count_d;  // Next count
    logic        running_d; // Next run state
    logic        underflow_d; // Next underflow pulse

    // Start loads, stop halts, tick counts down
    always_comb begin
        count_d     = count_q;
        running_d   = running_q;
        underflow_d = 1'b0;
        if (start) begin
            count_d   = reload;
            running_d = 1'b1;
        end else if (stop) begin
            running_d = 1'b0;
        end else if (running_q && tick) begin
            if (count_q == 16'h0000) begin
                // Trimming without underflow rests at zero
                if (!no_underflow) begin
                    underflow_d = 1'b1;
                    if (auto_restart) begin
                        count_d = reload;
                    end else begin
                        running_d = 1'b0;
                    end
                end
            end else begin
                count_d = count_q - 16'h0001;
            end
        end
    end

    // State registers
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            count_q     <= 16'h0000;
            running_q   <= 1'b0;
            underflow_q <= 1'b0;
        end else begin
            count_q     <= count_d;
            running_q   <= running_d;
            underflow_q <= underflow_d;
        end
    end
endmodule
`default_nettype wire

// [design/drct_top.sv]
// Top of the dual reload countdown timers, registers on AHB-Lite.
// Assumes tx_end, rx_first_bits and third_underflow come from logic on
// sys_clk; lfo_in is an asynchronous pin.
//
// The AHB-Lite interface to the registers was left to the implementer.
`timescale 1ns/1ns
`default_nettype none
module drct_top (
    input  wire logic        sys_clk,
    input  wire logic        rst_n,
    input  wire logic        hsel,
    input  wire logic [31:0] haddr,
    input  wire logic [1:0]  htrans,
    input  wire logic        hwrite,
    input  wire logic [2:0]  hsize,
    input  wire logic [31:0] hwdata,
    input  wire logic        hready,
    output logic             hreadyout,
    output logic             hresp,
    output logic      [31:0] hrdata,
    input  wire logic        tx_end,
    input  wire logic        rx_first_bits,
    input  wire logic        third_underflow,
    input  wire logic        lfo_in
);
    // ========================================
    // Declarations
    // Bus state
    logic        wr_pend_q, wr_pend_d;   // Write data phase pending
    logic [7:0]  wr_idx_q, wr_idx_d;     // Index of pending write
    logic [31:0] rdata_q, rdata_d;       // Read data register
    logic        addr_ok;                // Address phase accepted
    logic [7:0]  addr_idx;               // Index in address phase
    logic [7:0]  wbyte;                  // Written byte
    // Control registers
    drct_pkg::drct_ctrl_t ctrl0_q, ctrl0_d; // First timer control
    drct_pkg::drct_ctrl_t ctrl1_q, ctrl1_d; // Second timer control
    logic [15:0] rld0_q, rld0_d;         // First reload value
    logic [15:0] rld1_q, rld1_d;         // Second reload value
    logic        irq_q, irq_d;           // Second timer interrupt flag
    // Tick divider
    logic [13:0] phase_q, phase_d;       // Fast tick phase
    logic [5:0]  slow_q, slow_d;         // Slow tick prescaler
    logic        fast_tick;              // Fast tick enable
    logic        slow_tick;              // Slow tick enable
    // Oscillator input synchroniser
    logic        lfo_s1_q, lfo_s2_q, lfo_s3_q; // Three stage sampler
    logic        lfo_lvl_q, lfo_lvl_d;   // Agreed level
    logic        lfo_rise;               // Agreed rising edge
    // Timer links
    logic        run_wr;                 // Run control write
    logic [1:0]  t0_ev, t1_ev;           // Start and stop per timer
    logic        t0_tick, t1_tick;       // Selected ticks
    logic [15:0] t0_count, t1_count;     // Current counts
    logic        t0_run, t1_run;         // Running states
    logic        t0_uf, t1_uf;           // Underflow pulses

    // ========================================
    // Helpers
    // Start and stop events from the control settings
    function automatic logic [1:0] drct_events(
        input drct_pkg::drct_ctrl_t ctrl,
        input logic                 mask,
        input logic                 val,
        input logic                 running
    );
        logic trim;
        logic go;
        logic halt;
        trim = ctrl.start_mode[1];
        go   = run_wr && mask && val;
        halt = run_wr && mask && !val;
        if (ctrl.start_mode == drct_pkg::DRCT_START_TX_END) begin
            go = go || tx_end;
        end
        if (trim) begin
            go   = go || (lfo_rise && !running);
            halt = halt || (lfo_rise && running);
        end else if (ctrl.stop_rx) begin
            halt = halt || rx_first_bits;
        end
        return {go, halt};
    endfunction

    // Input clock selection
    function automatic logic drct_tick(
        input logic [1:0] sel,
        input logic       uf_a,
        input logic       uf_b
    );
        logic t;
        unique case (sel)
            2'h0: t = fast_tick;
            2'h1: t = slow_tick;
            2'h2: t = uf_a;
            2'h3: t = uf_b;
        endcase
        return t;
    endfunction

    // Register read mux
    function automatic logic [7:0] drct_read(input logic [7:0] idx);
        logic [7:0] r;
        r = 8'h00;
        unique case (idx)
            drct_pkg::IDX_RUN_CTRL:   r = {2'h0, t1_run, t0_run, 4'h0};
            drct_pkg::IDX_T0_CTRL:    r = ctrl0_q;
            drct_pkg::IDX_T0_RLD_HI:  r = rld0_q[15:8];
            drct_pkg::IDX_T0_RLD_LO:  r = rld0_q[7:0];
            drct_pkg::IDX_T0_CNT_HI:  r = t0_count[15:8];
            drct_pkg::IDX_T0_CNT_LO:  r = t0_count[7:0];
            drct_pkg::IDX_T1_CTRL:    r = ctrl1_q;
            drct_pkg::IDX_T1_RLD_HI:  r = rld1_q[15:8];
            drct_pkg::IDX_T1_RLD_LO:  r = rld1_q[7:0];
            drct_pkg::IDX_T1_CNT_HI:  r = t1_count[15:8];
            drct_pkg::IDX_T1_CNT_LO:  r = t1_count[7:0];
            drct_pkg::IDX_IRQ_STATUS: r = {7'h00, irq_q};
            default:                  r = 8'h00;
        endcase
        return r;
    endfunction

    // ========================================
    // Bus interface
    // Address phase decode and read data capture
    always_comb begin
        addr_ok   = hsel && hready && (htrans == drct_pkg::HTRANS_NONSEQ);
        addr_idx  = haddr[9:2];
        wr_pend_d = addr_ok && hwrite;
        wr_idx_d  = addr_ok ? addr_idx : wr_idx_q;
        rdata_d   = rdata_q;
        if (addr_ok && !hwrite) begin
            // Unmapped or high address reads zero
            if (haddr[31:10] == 22'h000000) begin
                rdata_d = {24'h000000, drct_read(addr_idx)};
            end else begin
                rdata_d = 32'h00000000;
            end
        end
        wbyte  = hwdata[7:0];
        run_wr = wr_pend_q && (wr_idx_q == drct_pkg::IDX_RUN_CTRL);
    end

    // Bus registers; the slave never stalls or errors
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            wr_pend_q <= 1'b0;
            wr_idx_q  <= 8'h00;
            rdata_q   <= 32'h00000000;
            hreadyout <= 1'b0;
            hresp     <= 1'b0;
        end else begin
            wr_pend_q <= wr_pend_d;
            wr_idx_q  <= wr_idx_d;
            rdata_q   <= rdata_d;
            hreadyout <= 1'b1;
            hresp     <= 1'b0;
        end
    end

    // Read data straight from its register
    always_comb begin
        hrdata = rdata_q;
    end

    // ========================================
    // Control and reload registers
    // Data phase writes; reserved bits forced to zero
    always_comb begin
        ctrl0_d = ctrl0_q;
        ctrl1_d = ctrl1_q;
        rld0_d  = rld0_q;
        rld1_d  = rld1_q;
        if (wr_pend_q) begin
            unique case (wr_idx_q)
                drct_pkg::IDX_T0_CTRL:   ctrl0_d = wbyte & drct_pkg::CTRL_WR_MASK;
                drct_pkg::IDX_T1_CTRL:   ctrl1_d = wbyte & drct_pkg::CTRL_WR_MASK;
                drct_pkg::IDX_T0_RLD_HI: rld0_d[15:8] = wbyte;
                drct_pkg::IDX_T0_RLD_LO: rld0_d[7:0]  = wbyte;
                drct_pkg::IDX_T1_RLD_HI: rld1_d[15:8] = wbyte;
                drct_pkg::IDX_T1_RLD_LO: rld1_d[7:0]  = wbyte;
                default: ;
            endcase
        end
        // Flag set wins over a same-cycle clear
        irq_d = irq_q;
        if (wr_pend_q && (wr_idx_q == drct_pkg::IDX_IRQ_STATUS)
            && wbyte[drct_pkg::IRQ_FLAG_BIT]) begin
            irq_d = 1'b0;
        end
        if (t1_uf) begin
            irq_d = 1'b1;
        end
    end

    // Control registers
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            ctrl0_q <= drct_pkg::CTRL_RST;
            ctrl1_q <= drct_pkg::CTRL_RST;
            rld0_q  <= drct_pkg::RELOAD_RST;
            rld1_q  <= drct_pkg::RELOAD_RST;
            irq_q   <= 1'b0;
        end else begin
            ctrl0_q <= ctrl0_d;
            ctrl1_q <= ctrl1_d;
            rld0_q  <= rld0_d;
            rld1_q  <= rld1_d;
            irq_q   <= irq_d;
        end
    end

    // ========================================
    // Tick divider
    // Fractional fast tick, slow tick every 64 fast ticks
    always_comb begin
        fast_tick = (phase_q >= (drct_pkg::FAST_MOD - drct_pkg::FAST_STEP));
        if (fast_tick) begin
            phase_d = phase_q + drct_pkg::FAST_STEP - drct_pkg::FAST_MOD;
        end else begin
            phase_d = phase_q + drct_pkg::FAST_STEP;
        end
        slow_tick = fast_tick && (slow_q == drct_pkg::SLOW_LAST);
        if (fast_tick) begin
            slow_d = slow_tick ? 6'h00 : slow_q + 6'h01;
        end else begin
            slow_d = slow_q;
        end
    end

    // Divider registers
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            phase_q <= 14'h0000;
            slow_q  <= 6'h00;
        end else begin
            phase_q <= phase_d;
            slow_q  <= slow_d;
        end
    end

    // ========================================
    // Oscillator input
    // Level changes once stages two and three agree
    always_comb begin
        lfo_lvl_d = (lfo_s2_q == lfo_s3_q) ? lfo_s3_q : lfo_lvl_q;
        lfo_rise  = (lfo_s2_q == lfo_s3_q) && lfo_s3_q && !lfo_lvl_q;
    end

    // Synchroniser registers
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            lfo_s1_q  <= 1'b0;
            lfo_s2_q  <= 1'b0;
            lfo_s3_q  <= 1'b0;
            lfo_lvl_q <= 1'b0;
        end else begin
            lfo_s1_q  <= lfo_in;
            lfo_s2_q  <= lfo_s1_q;
            lfo_s3_q  <= lfo_s2_q;
            lfo_lvl_q <= lfo_lvl_d;
        end
    end

    // ========================================
    // Timers
    // Events and ticks per timer
    always_comb begin
        t0_ev   = drct_events(ctrl0_q, wbyte[drct_pkg::RUN_MASK_T0],
                              wbyte[drct_pkg::RUN_STATE_T0], t0_run);
        t1_ev   = drct_events(ctrl1_q, wbyte[drct_pkg::RUN_MASK_T1],
                              wbyte[drct_pkg::RUN_STATE_T1], t1_run);
        t0_tick = drct_tick(ctrl0_q.clk_sel, third_underflow, t1_uf);
        t1_tick = drct_tick(ctrl1_q.clk_sel, t0_uf, third_underflow);
    end

    // First timer
    drct_countdown u_first (
        .sys_clk      (sys_clk),
        .rst_n        (rst_n),
        .tick         (t0_tick),
        .start        (t0_ev[1]),
        .stop         (t0_ev[0]),
        .no_underflow (ctrl0_q.start_mode == drct_pkg::DRCT_START_TRIM),
        .auto_restart (ctrl0_q.auto_restart),
        .reload       (rld0_q),
        .count_q      (t0_count),
        .running_q    (t0_run),
        .underflow_q  (t0_uf)
    );

    // Second timer
    drct_countdown u_second (
        .sys_clk      (sys_clk),
        .rst_n        (rst_n),
        .tick         (t1_tick),
        .start        (t1_ev[1]),
        .stop         (t1_ev[0]),
        .no_underflow (ctrl1_q.start_mode == drct_pkg::DRCT_START_TRIM),
        .auto_restart (ctrl1_q.auto_restart),
        .reload       (rld1_q),
        .count_q      (t1_count),
        .running_q    (t1_run),
        .underflow_q  (t1_uf)
    );
endmodule
`default_nettype wire

// [testbench/drct_checker.sv]
// Bus-side assertions for the timer block, bound to drct_top.
// Assumes one sys_clk domain and a zero-wait AHB-Lite slave.
`timescale 1ns/1ns
`default_nettype none
module drct_checker (
    input wire logic        sys_clk,
    input wire logic        rst_n,
    input wire logic        hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0]  htrans,
    input wire logic        hwrite,
    input wire logic [31:0] hwdata,
    input wire logic        hready,
    input wire logic        hreadyout,
    input wire logic        hresp,
    input wire logic [31:0] hrdata,
    input wire logic        tx_end
);
    // ========================================
    // Helper state
    logic       take;    // Address phase taken
    logic       rd_take; // Read address phase taken
    logic       wp_q;    // Write data phase to first reload low
    logic       wp_d;
    logic [7:0] rl_q;    // Last byte written there
    logic [7:0] rl_d;
    assign take    = hsel && hready && htrans == drct_pkg::HTRANS_NONSEQ;
    assign rd_take = take && !hwrite;
    // Next helper values
    always_comb begin
        wp_d = take && hwrite && haddr == 32'h0000_0044;
        rl_d = (wp_q && hready) ? hwdata[7:0] : rl_q;
    end
    // Helper registers
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            wp_q <= 1'b0;
            rl_q <= 8'h00;
        end else begin
            wp_q <= wp_d;
            rl_q <= rl_d;
        end
    end
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (!rst_n);
    // ========================================
    // Assertions
    AST_SECOND_RSVD_ZERO: assert property (
        rd_take && haddr == 32'h0000_0050 |=> hrdata[6] == 1'b0 && hrdata[2] == 1'b0)
        else $error("second control reserved bits not zero");
    AST_FIRST_RSVD_ZERO: assert property (
        rd_take && haddr == 32'h0000_003C |=> hrdata[6] == 1'b0 && hrdata[2] == 1'b0)
        else $error("first control reserved bits not zero");
    AST_RUN_UNUSED_ZERO: assert property (
        rd_take && haddr == 32'h0000_0038 |=> hrdata[7:6] == 2'h0 && hrdata[3:0] == 4'h0)
        else $error("run control unused bits not zero");
    AST_UNMAPPED_ZERO: assert property (
        rd_take && (haddr[31:10] != 22'h0 || haddr[9:2] == 8'h1F) |=> hrdata == 32'h0)
        else $error("unmapped read not zero");
    AST_BYTE_WIDE: assert property (hrdata[31:8] == 24'h0)
        else $error("upper read data bits not zero");
    AST_RELOAD_READBACK: assert property (
        rd_take && haddr == 32'h0000_0044 && !wp_q |=> hrdata[7:0] == rl_q)
        else $error("first reload low read back wrong");
    AST_RDATA_HOLDS: assert property (!rd_take |=> $stable(hrdata))
        else $error("read data moved without a read");
    AST_READY_ZERO_WAIT: assert property ($past(rst_n) |-> hreadyout)
        else $error("wait state inserted");
    AST_RESP_OKAY: assert property (hresp == 1'b0)
        else $error("error response on the bus");
    // Main scenarios reached
    COV_SECOND_CTRL_READ: cover property (rd_take && haddr == 32'h0000_0050);
    COV_TX_END: cover property (tx_end);
    COV_STATUS_READ: cover property (rd_take && haddr == 32'h0000_0080);
endmodule
bind drct_top drct_checker i_chk (
    .sys_clk(sys_clk), .rst_n(rst_n), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hwdata(hwdata), .hready(hready), .hreadyout(hreadyout), .hresp(hresp),
    .hrdata(hrdata), .tx_end(tx_end)
);
`default_nettype wire

// [testbench/testbench.sv]
// Self-checking bench for the timer block over AHB-Lite.
// Assumes the package, design and bound checker compile first.
`timescale 1ns/1ns
`default_nettype none
module testbench;
    // ========================================
    // Signals
    logic        sys_clk;
    logic        rst_n   = 1'b0;
    logic        hsel    = 1'b0;
    logic [31:0] haddr   = 32'h0;
    logic [1:0]  htrans  = 2'h0;
    logic        hwrite  = 1'b0;
    logic [2:0]  hsize   = 3'h2;  // Whole words only
    logic [31:0] hwdata  = 32'h0;
    logic [2:0]  ev      = 3'h0;  // Pulses: tx end, rx bits, third underflow
    logic        lfo_in  = 1'b0;  // Oscillator pin
    logic        rd_pend = 1'b0;  // Read data phase under way
    logic [63:0] exp_q[$];        // Notes: mask and value
    logic [63:0] note;            // Oldest note
    logic [7:0]  b;               // Random byte
    int          err_total   = 0;
    int          check_count = 0;
    wire         hready;
    wire         hreadyout;
    wire         hresp;
    wire  [31:0] hrdata;
    assign hready = hreadyout;
    drct_top i_dut (
        .sys_clk(sys_clk), .rst_n(rst_n), .hsel(hsel), .haddr(haddr), .htrans(htrans),
        .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hready),
        .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata), .tx_end(ev[2]),
        .rx_first_bits(ev[1]), .third_underflow(ev[0]), .lfo_in(lfo_in)
    );
    // ========================================
    // Clock
    initial begin
        sys_clk = 1'b0;
        forever #5 sys_clk = ~sys_clk;
    end
    // ========================================
    // Tasks
    function automatic logic [31:0] ad(input logic [7:0] i);
        return {22'h0, i, 2'h0};
    endfunction
    // One transfer; each phase held until hready
    task automatic bus(input logic w, input logic [31:0] a, input logic [31:0] d);
        hsel   <= 1'b1;
        haddr  <= a;
        htrans <= drct_pkg::HTRANS_NONSEQ;
        hwrite <= w;
        do @(posedge sys_clk); while (hready !== 1'b1);
        htrans <= 2'h0;
        hwdata <= d;
        do @(posedge sys_clk); while (hready !== 1'b1);
    endtask
    // Byte write, random upper bits
    task automatic wr(input logic [7:0] i, input logic [7:0] d);
        bus(1'b1, ad(i), {24'($urandom()), d});
    endtask
    // Read, after state settles; expectation noted
    task automatic rd(input logic [31:0] a, input logic [7:0] e, input logic [7:0] m);
        repeat (2) @(posedge sys_clk);
        exp_q.push_back({24'hFFFFFF, m, 24'h0, e});
        bus(1'b0, a, $urandom());
    endtask
    // Masked compare of read data
    task automatic chk(input logic [31:0] g, input logic [31:0] e, input logic [31:0] m);
        check_count++;
        if ((g & m) !== (e & m)) begin
            err_total++;
            $display("mismatch at %0t: read %h, expected %h", $time, g, e);
        end
    endtask
    // Event pulses, spaced for cascaded ticks
    task automatic pulse(input logic [2:0] s, input int n);
        repeat (n) begin
            ev <= s;
            @(posedge sys_clk);
            ev <= 3'h0;
            repeat (5) @(posedge sys_clk);
        end
    endtask
    // Verdict and end of run
    task automatic complete_run;
        $display("Comparisons %0d, mismatches %0d", check_count, err_total);
        if (err_total == 0 && check_count > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    endtask
    // ========================================
    // Monitor: oldest note against each read result
    always @(posedge sys_clk) begin
        if (rd_pend && hreadyout === 1'b1) begin
            note = exp_q.pop_front();
            chk(hrdata, note[31:0], note[63:32]);
        end
        rd_pend <= rst_n && hsel && hready && htrans == drct_pkg::HTRANS_NONSEQ && !hwrite;
    end
    // Watchdog
    initial begin
        #500000;
        err_total++;
        complete_run();
    end
    // ========================================
    // Main sequence
    initial begin
        void'($urandom(32'h37D78C1C));
        repeat (12) @(posedge sys_clk);
        rst_n <= 1'b1;
        repeat (2) @(posedge sys_clk);
        for (int i = 14; i <= 24; i++)
            rd(ad(8'(i)), 8'h00, 8'hFF);
        rd(ad(8'h20), 8'h00, 8'hFF);
        // Register access, control masked to live bits
        for (int i = 15; i <= 22; i++) begin
            if (i == 18 || i == 19)
                continue;
            b = 8'($urandom());
            wr(8'(i), b);
            if (i == 15 || i == 20)
                b = b & 8'hBB;
            rd(ad(8'(i)), b, 8'hFF);
        end
        wr(8'h12, 8'hA5);
        rd(ad(8'h12), 8'h00, 8'hFF);
        wr(8'h1F, 8'h5A);
        rd(ad(8'h1F), 8'h00, 8'hFF);
        rd(32'h0000_0444, 8'h00, 8'hFF);
        // Cascade: third underflow ticks first, first underflow ticks second
        wr(8'h0F, 8'h0A);
        wr(8'h10, 8'h00);
        wr(8'h11, 8'h02);
        wr(8'h14, 8'h02);
        wr(8'h15, 8'h00);
        wr(8'h16, 8'h10);
        wr(8'h0E, 8'h33);
        rd(ad(8'h13), 8'h02, 8'hFF);
        rd(ad(8'h18), 8'h10, 8'hFF);
        wr(8'h16, 8'h40);
        pulse(3'h1, 6);
        rd(ad(8'h13), 8'h02, 8'hFF);
        rd(ad(8'h18), 8'h0E, 8'hFF);
        rd(ad(8'h0E), 8'h30, 8'hFF);
        wr(8'h0E, 8'h03);
        rd(ad(8'h0E), 8'h00, 8'hFF);
        wr(8'h0E, 8'h30);
        rd(ad(8'h0E), 8'h00, 8'hFF);
        // Second clocked by third underflow, then receive stop
        wr(8'h14, 8'h83);
        wr(8'h0E, 8'h22);
        pulse(3'h1, 3);
        rd(ad(8'h18), 8'h3D, 8'hFF);
        pulse(3'h2, 1);
        rd(ad(8'h0E), 8'h00, 8'h20);
        rd(ad(8'h18), 8'h3D, 8'hFF);
        wr(8'h14, 8'hB3);
        wr(8'h0E, 8'h22);
        pulse(3'h2, 1);
        rd(ad(8'h0E), 8'h20, 8'h20);
        wr(8'h14, 8'h03);
        pulse(3'h2, 1);
        rd(ad(8'h0E), 8'h20, 8'h20);
        // Start on end of transmission, none in mode 00
        wr(8'h0E, 8'h02);
        wr(8'h14, 8'h13);
        wr(8'h16, 8'h50);
        pulse(3'h4, 1);
        rd(ad(8'h0E), 8'h20, 8'h20);
        rd(ad(8'h18), 8'h50, 8'hFF);
        wr(8'h0E, 8'h02);
        wr(8'h14, 8'h03);
        pulse(3'h4, 1);
        rd(ad(8'h0E), 8'h00, 8'h20);
        // Trimming: oscillator rises start then stop
        wr(8'h14, 8'h23);
        lfo_in <= 1'b1;
        repeat (10) @(posedge sys_clk);
        rd(ad(8'h0E), 8'h20, 8'h20);
        lfo_in <= 1'b0;
        repeat (10) @(posedge sys_clk);
        lfo_in <= 1'b1;
        repeat (10) @(posedge sys_clk);
        rd(ad(8'h0E), 8'h00, 8'h20);
        // First timer receive stop
        wr(8'h0F, 8'h83);
        wr(8'h0E, 8'h11);
        pulse(3'h2, 1);
        rd(ad(8'h0E), 8'h00, 8'h10);
        // Fast clock underflow without restart, then flag clear
        wr(8'h14, 8'h00);
        wr(8'h15, 8'h00);
        wr(8'h16, 8'h03);
        wr(8'h0E, 8'h22);
        repeat (200) @(posedge sys_clk);
        rd(ad(8'h0E), 8'h00, 8'h20);
        rd(ad(8'h18), 8'h00, 8'hFF);
        rd(ad(8'h20), 8'h01, 8'h01);
        wr(8'h20, 8'h01);
        rd(ad(8'h20), 8'h00, 8'h01);
        // First timer counts second underflows and stops at zero
        wr(8'h0F, 8'h03);
        wr(8'h14, 8'h08);
        wr(8'h0E, 8'h33);
        repeat (200) @(posedge sys_clk);
        rd(ad(8'h0E), 8'h20, 8'h30);
        rd(ad(8'h13), 8'h00, 8'hFF);
        rd(ad(8'h20), 8'h01, 8'h01);
        // Slow tick: two ticks lie far apart, one fast span is short
        wr(8'h14, 8'h01);
        wr(8'h16, 8'h01);
        wr(8'h0E, 8'h22);
        repeat (300) @(posedge sys_clk);
        rd(ad(8'h0E), 8'h20, 8'h20);
        repeat (1000) @(posedge sys_clk);
        rd(ad(8'h0E), 8'h00, 8'h20);
        rd(ad(8'h18), 8'h00, 8'hFF);
        repeat (4) @(posedge sys_clk);
        complete_run();
    end
endmodule
`default_nettype wire
